//--- rtl/socs_top.sv
`timescale 1ns/1ps
`include "socs_params.svh"

// What this block does
// - Unlock register survives low-leakage stop exit
// - Stop standby writable only after unlock bit 26
// - Stop standby unlock clears after that write
// - Low-power standby writable after unlock bit 25
// - Low-power standby unlock clears after write
// - Regulator enable writable after unlock bit 24
// - Regulator enable unlock clears after write
// - Locked regulator bits ignore writes
// - Reserved fields read zero
// - Serial clock select: off, loop, internal
// - Timer clock select: off, loop, oscillator
// - USB clock from bypass or loop
// - Loop choice feeds peripheral clock selects
// - Loop choice: frequency clock or halved phase
// - General pin: bus or oscillator clock
// - RTC pin: 1 Hz or oscillator clock
// - Regulator enable bit drives regulator on
// - Stop standby bit applies during stop modes
module socs_top (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire socs_pkg::socs_bus_s bus,
    output logic [31:0] rd_data,
    input wire logic very_low_leakage_stop_exit,
    input wire logic stop_mode,
    input wire logic lowpower_run,
    input wire socs_pkg::socs_clk_in_s clk_in,
    output socs_pkg::socs_clk_out_s clk_out,
    output socs_pkg::socs_reg_out_s reg_out
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ****************************************************************
    // Decode
    // ****************************************************************
    socs_pkg::socs_state_s s_q;
    socs_pkg::socs_state_s s_d;
    logic wr_option;
    logic wr_unlock;
    logic wr_clksrc;
    logic loop_clk;

    function automatic logic hit(input logic [12:0] addr, input logic [12:0] ofs);
        hit = (addr == ofs);
    endfunction

    assign wr_option = bus.wr && hit(bus.addr, `SOCS_OFS_OPTION);
    assign wr_unlock = bus.wr && hit(bus.addr, `SOCS_OFS_UNLOCK);
    assign wr_clksrc = bus.wr && hit(bus.addr, `SOCS_OFS_CLKSRC);

    // Loop clock shared by the serial, timer and USB selects.
    assign loop_clk = s_q.loop_sel ? s_q.pll_half : clk_in.frequency_locked_clock;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        // Halve the phase-locked clock on each sampled rising edge.
        s_d.pll_prev = clk_in.phase_locked_clock;
        if (clk_in.phase_locked_clock && !s_q.pll_prev) begin
            s_d.pll_half = !s_q.pll_half;
        end

        // A wake from low-leakage stop resets the option and clock source registers, not the unlock bits.
        if (very_low_leakage_stop_exit) begin
            s_d.reg_on = 1'b0;
            s_d.stop_sby = 1'b0;
            s_d.lp_sby = 1'b0;
            s_d.serial_sel = `SOCS_RST_SERIAL_SEL;
            s_d.timer_sel = `SOCS_RST_TIMER_SEL;
            s_d.usb_sel = 1'b0;
            s_d.loop_sel = 1'b0;
            s_d.gen_sel = `SOCS_RST_GEN_SEL;
            s_d.rtc_sel = 1'b0;
        end

        if (wr_unlock) begin
            s_d.unlock[2] = s_q.unlock[2] | bus.wdata[`SOCS_POS_STOP_UNLOCK];
            s_d.unlock[1] = s_q.unlock[1] | bus.wdata[`SOCS_POS_LP_UNLOCK];
            s_d.unlock[0] = s_q.unlock[0] | bus.wdata[`SOCS_POS_REG_UNLOCK];
        end

        if (wr_option) begin
            if (s_q.unlock[2]) begin
                s_d.stop_sby = bus.wdata[`SOCS_POS_STOP_SBY];
                s_d.unlock[2] = 1'b0;
            end
            if (s_q.unlock[1]) begin
                s_d.lp_sby = bus.wdata[`SOCS_POS_LP_SBY];
                s_d.unlock[1] = 1'b0;
            end
            if (s_q.unlock[0]) begin
                s_d.reg_on = bus.wdata[`SOCS_POS_REG_ON];
                s_d.unlock[0] = 1'b0;
            end
        end

        if (wr_clksrc) begin
            s_d.serial_sel = bus.wdata[`SOCS_POS_SERIAL_SEL +: 2];
            s_d.timer_sel = bus.wdata[`SOCS_POS_TIMER_SEL +: 2];
            s_d.usb_sel = bus.wdata[`SOCS_POS_USB_SEL];
            s_d.loop_sel = bus.wdata[`SOCS_POS_LOOP_SEL];
            s_d.gen_sel = bus.wdata[`SOCS_POS_GEN_SEL +: 3];
            s_d.rtc_sel = bus.wdata[`SOCS_POS_RTC_SEL];
        end

        // Read data stands only in the cycle after the strobe.
        s_d.rd_data = 32'h0000_0000;
        if (bus.rd) begin
            case (bus.addr)
                `SOCS_OFS_OPTION: begin
                    s_d.rd_data[`SOCS_POS_REG_ON] = s_q.reg_on;
                    s_d.rd_data[`SOCS_POS_STOP_SBY] = s_q.stop_sby;
                    s_d.rd_data[`SOCS_POS_LP_SBY] = s_q.lp_sby;
                end
                `SOCS_OFS_UNLOCK: begin
                    s_d.rd_data[`SOCS_POS_REG_UNLOCK +: 3] = s_q.unlock;
                end
                `SOCS_OFS_CLKSRC: begin
                    s_d.rd_data[`SOCS_POS_SERIAL_SEL +: 2] = s_q.serial_sel;
                    s_d.rd_data[`SOCS_POS_TIMER_SEL +: 2] = s_q.timer_sel;
                    s_d.rd_data[`SOCS_POS_USB_SEL] = s_q.usb_sel;
                    s_d.rd_data[`SOCS_POS_LOOP_SEL] = s_q.loop_sel;
                    s_d.rd_data[`SOCS_POS_GEN_SEL +: 3] = s_q.gen_sel;
                    s_d.rd_data[`SOCS_POS_RTC_SEL] = s_q.rtc_sel;
                end
                default: begin
                    s_d.rd_data = 32'h0000_0000;
                end
            endcase
        end

        // Clock selection, registered on the system clock.
        case (s_q.serial_sel)
            socs_pkg::SOCS_SER_LOOP: s_d.clk_out.serial_port_clock = loop_clk;
            socs_pkg::SOCS_SER_IRC: begin
                s_d.clk_out.serial_port_clock = clk_in.internal_reference_clock;
            end
            default: s_d.clk_out.serial_port_clock = 1'b0;
        endcase
        case (s_q.timer_sel)
            socs_pkg::SOCS_TMR_LOOP: s_d.clk_out.timer_clock = loop_clk;
            socs_pkg::SOCS_TMR_OSC: begin
                s_d.clk_out.timer_clock = clk_in.oscillator_reference_clock;
            end
            default: s_d.clk_out.timer_clock = 1'b0;
        endcase
        s_d.clk_out.usb_48m_clock = s_q.usb_sel ? loop_clk : clk_in.usb_bypass_clock_input;
        case (s_q.gen_sel)
            socs_pkg::SOCS_GEN_BUS: s_d.clk_out.general_clock_output_pin = clk_in.bus_clock;
            socs_pkg::SOCS_GEN_OSC: begin
                s_d.clk_out.general_clock_output_pin = clk_in.oscillator_reference_clock;
            end
            default: s_d.clk_out.general_clock_output_pin = 1'b0;
        endcase
        s_d.clk_out.rtc_clock_output_pin = s_q.rtc_sel ? clk_in.oscillator_reference_clock
                                                       : clk_in.rtc_1hz_clock;
        s_d.standby = (stop_mode && s_q.stop_sby) || (lowpower_run && s_q.lp_sby);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd_data;
    assign clk_out = s_q.clk_out;
    assign reg_out.regulator_on = s_q.reg_on;
    assign reg_out.regulator_stop_standby = s_q.stop_sby;
    assign reg_out.regulator_lowpower_standby = s_q.lp_sby;
    assign reg_out.regulator_in_standby = s_q.standby;

    // ****************************************************************
    // Checks
    // ****************************************************************
    unlock_keep_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (very_low_leakage_stop_exit && !bus.wr) |=> $stable(s_q.unlock))
    else $error("Unlock bits changed on low-leakage wake.");

    stop_write_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_option && s_q.unlock[2] && !very_low_leakage_stop_exit)
        |=> reg_out.regulator_stop_standby == $past(bus.wdata[`SOCS_POS_STOP_SBY]))
    else $error("Unlocked stop standby write not taken.");

    stop_clear_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_option |=> !s_q.unlock[2])
    else $error("Stop standby unlock not cleared.");

    lp_write_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_option && s_q.unlock[1] && !very_low_leakage_stop_exit)
        |=> reg_out.regulator_lowpower_standby == $past(bus.wdata[`SOCS_POS_LP_SBY]))
    else $error("Unlocked low-power standby write not taken.");

    lp_clear_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_option && s_q.unlock[1]) |=> !s_q.unlock[1])
    else $error("Low-power standby unlock not cleared.");

    regon_write_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_option && s_q.unlock[0] && !very_low_leakage_stop_exit)
        |=> reg_out.regulator_on == $past(bus.wdata[`SOCS_POS_REG_ON]))
    else $error("Unlocked regulator enable write not taken.");

    regon_clear_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_option && s_q.unlock[0]) |=> !s_q.unlock[0])
    else $error("Regulator enable unlock not cleared.");

    locked_hold_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (!s_q.unlock[0] && !very_low_leakage_stop_exit) |=> $stable(reg_out.regulator_on))
    else $error("Locked regulator enable changed.");

    reserved_zero_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (bus.rd && bus.addr == `SOCS_OFS_UNLOCK)
        |=> rd_data[31:27] == 5'h00 && rd_data[23:0] == 24'h00_0000)
    else $error("Reserved unlock field read nonzero.");

    serial_off_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s_q.serial_sel == 2'b00) [*2] |-> !clk_out.serial_port_clock)
    else $error("Serial clock runs while disabled.");

    timer_osc_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s_q.timer_sel == 2'b10)
        |=> clk_out.timer_clock == $past(clk_in.oscillator_reference_clock))
    else $error("Timer clock not from oscillator.");

    usb_bypass_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !s_q.usb_sel |=> clk_out.usb_48m_clock == $past(clk_in.usb_bypass_clock_input))
    else $error("USB clock not from bypass input.");

    loop_fll_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (!s_q.loop_sel && s_q.usb_sel)
        |=> clk_out.usb_48m_clock == $past(clk_in.frequency_locked_clock))
    else $error("Loop clock not from frequency clock.");

    gen_bus_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s_q.gen_sel == 3'b010)
        |=> clk_out.general_clock_output_pin == $past(clk_in.bus_clock))
    else $error("General pin not carrying bus clock.");

    rtc_pin_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !s_q.rtc_sel |=> clk_out.rtc_clock_output_pin == $past(clk_in.rtc_1hz_clock))
    else $error("RTC pin not carrying 1 Hz clock.");

    stop_sby_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (stop_mode && reg_out.regulator_stop_standby) |=> reg_out.regulator_in_standby)
    else $error("Regulator not in standby during stop.");

    rd_idle_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !bus.rd |=> rd_data == 32'h0000_0000)
    else $error("Read data not zero outside a read.");

    option_zero_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (bus.rd && bus.addr == `SOCS_OFS_OPTION)
        |=> rd_data[28:0] == 29'h0)
    else $error("Reserved option field read nonzero.");

    clksrc_zero_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (bus.rd && bus.addr == `SOCS_OFS_CLKSRC)
        |=> rd_data[31:28] == 4'h0 && rd_data[23:19] == 5'h00 && rd_data[17] == 1'b0
            && rd_data[15:8] == 8'h00 && rd_data[3:0] == 4'h0)
    else $error("Reserved clock source field read nonzero.");

    serial_irc_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s_q.serial_sel == 2'b11)
        |=> clk_out.serial_port_clock == $past(clk_in.internal_reference_clock))
    else $error("Serial clock not from internal reference.");

    serial_loop_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s_q.serial_sel == 2'b01 && !s_q.loop_sel)
        |=> clk_out.serial_port_clock == $past(clk_in.frequency_locked_clock))
    else $error("Serial clock not from loop clock.");

    timer_off_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s_q.timer_sel == 2'b00) [*2] |-> !clk_out.timer_clock)
    else $error("Timer clock runs while disabled.");

    usb_pll_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s_q.usb_sel && s_q.loop_sel)
        |=> clk_out.usb_48m_clock == $past(s_q.pll_half))
    else $error("USB clock not from halved phase clock.");

    pll_half_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (clk_in.phase_locked_clock && !s_q.pll_prev)
        |=> s_q.pll_half != $past(s_q.pll_half))
    else $error("Phase clock halver missed an edge.");

    gen_osc_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s_q.gen_sel == 3'b110)
        |=> clk_out.general_clock_output_pin == $past(clk_in.oscillator_reference_clock))
    else $error("General pin not carrying oscillator clock.");

    rtc_osc_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_q.rtc_sel
        |=> clk_out.rtc_clock_output_pin == $past(clk_in.oscillator_reference_clock))
    else $error("RTC pin not carrying oscillator clock.");

    stop_locked_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (!s_q.unlock[2] && !very_low_leakage_stop_exit) |=> $stable(reg_out.regulator_stop_standby))
    else $error("Locked stop standby changed.");

    lp_locked_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (!s_q.unlock[1] && !very_low_leakage_stop_exit) |=> $stable(reg_out.regulator_lowpower_standby))
    else $error("Locked low-power standby changed.");

endmodule // socs_top

//--- rtl/socs_params.svh
`ifndef SOCS_PARAMS_SVH
`define SOCS_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SOCS_ADDR_W 13
`define SOCS_OFS_OPTION 13'h0000
`define SOCS_OFS_UNLOCK 13'h0004
`define SOCS_OFS_CLKSRC 13'h1004

// ****************************************************************
// Field positions
// ****************************************************************
`define SOCS_POS_REG_ON 31
`define SOCS_POS_STOP_SBY 30
`define SOCS_POS_LP_SBY 29
`define SOCS_POS_STOP_UNLOCK 26
`define SOCS_POS_LP_UNLOCK 25
`define SOCS_POS_REG_UNLOCK 24
`define SOCS_POS_SERIAL_SEL 26
`define SOCS_POS_TIMER_SEL 24
`define SOCS_POS_USB_SEL 18
`define SOCS_POS_LOOP_SEL 16
`define SOCS_POS_GEN_SEL 5
`define SOCS_POS_RTC_SEL 4

// ****************************************************************
// Reset values
// ****************************************************************
`define SOCS_RST_UNLOCK 3'h0
`define SOCS_RST_OPTION 3'h0
`define SOCS_RST_SERIAL_SEL 2'h0
`define SOCS_RST_TIMER_SEL 2'h0
`define SOCS_RST_GEN_SEL 3'h0

`endif

//--- rtl/socs_pkg.sv
package socs_pkg;

    // ****************************************************************
    // Clock source encodings
    // ****************************************************************
    typedef enum logic [1:0] {
        SOCS_SER_OFF = 2'b00,
        SOCS_SER_LOOP = 2'b01,
        SOCS_SER_IRC = 2'b11
    } socs_serial_sel_e;

    typedef enum logic [1:0] {
        SOCS_TMR_OFF = 2'b00,
        SOCS_TMR_LOOP = 2'b01,
        SOCS_TMR_OSC = 2'b10
    } socs_timer_sel_e;

    typedef enum logic [2:0] {
        SOCS_GEN_BUS = 3'b010,
        SOCS_GEN_OSC = 3'b110
    } socs_gen_sel_e;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [12:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } socs_bus_s;

    typedef struct packed {
        logic frequency_locked_clock;
        logic phase_locked_clock;
        logic internal_reference_clock;
        logic oscillator_reference_clock;
        logic usb_bypass_clock_input;
        logic bus_clock;
        logic rtc_1hz_clock;
    } socs_clk_in_s;

    typedef struct packed {
        logic serial_port_clock;
        logic timer_clock;
        logic usb_48m_clock;
        logic general_clock_output_pin;
        logic rtc_clock_output_pin;
    } socs_clk_out_s;

    typedef struct packed {
        logic regulator_on;
        logic regulator_stop_standby;
        logic regulator_lowpower_standby;
        logic regulator_in_standby;
    } socs_reg_out_s;

    typedef struct packed {
        logic [2:0] unlock;
        logic reg_on;
        logic stop_sby;
        logic lp_sby;
        logic [1:0] serial_sel;
        logic [1:0] timer_sel;
        logic usb_sel;
        logic loop_sel;
        logic [2:0] gen_sel;
        logic rtc_sel;
        logic pll_prev;
        logic pll_half;
        logic [31:0] rd_data;
        socs_clk_out_s clk_out;
        logic standby;
    } socs_state_s;

endpackage

//--- tb/tb.sv
`timescale 1ns/1ps
`include "socs_params.svh"

module tb;
    logic clk_sys;
    logic rst_b;
    socs_pkg::socs_bus_s bus;
    logic [31:0] rd_data;
    logic very_low_leakage_stop_exit;
    logic stop_mode;
    logic lowpower_run;
    socs_pkg::socs_clk_in_s clk_in;
    socs_pkg::socs_clk_out_s clk_out;
    socs_pkg::socs_reg_out_s reg_out;
    int n_mismatch;
    int n_tests;
    logic [31:0] w;
    logic [6:0] pat;
    logic [4:0] prev;
    int nt [3];

    socs_top socs_top_i (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .bus(bus),
        .rd_data(rd_data),
        .very_low_leakage_stop_exit(very_low_leakage_stop_exit),
        .stop_mode(stop_mode),
        .lowpower_run(lowpower_run),
        .clk_in(clk_in),
        .clk_out(clk_out),
        .reg_out(reg_out)
    );

    // ****************************************************************
    // Clock and bus tasks
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
            n_mismatch++;
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd_chk(input logic [12:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1;
        check(rd_data, e);
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic logic [4:0] exp_clk(input logic [31:0] s, input socs_pkg::socs_clk_in_s c);
        logic a;
        logic b;
        logic u;
        logic g;
        logic r;
        a = (s[27:26] == 2'b01) ? c.frequency_locked_clock :
            (s[27:26] == 2'b11) ? c.internal_reference_clock : 1'b0;
        b = (s[25:24] == 2'b01) ? c.frequency_locked_clock :
            (s[25:24] == 2'b10) ? c.oscillator_reference_clock : 1'b0;
        u = s[18] ? c.frequency_locked_clock : c.usb_bypass_clock_input;
        g = (s[7:5] == 3'b010) ? c.bus_clock :
            (s[7:5] == 3'b110) ? c.oscillator_reference_clock : 1'b0;
        r = s[4] ? c.oscillator_reference_clock : c.rtc_1hz_clock;
        return {a, b, u, g, r};
    endfunction

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        n_mismatch = 0;
        n_tests = 0;
        rst_b = 1'b0;
        bus = '0;
        very_low_leakage_stop_exit = 1'b0;
        stop_mode = 1'b0;
        lowpower_run = 1'b0;
        clk_in = '0;
        do_reset();
        rd_chk(13'h0000, 32'h0000_0000);
        rd_chk(13'h0004, 32'h0000_0000);
        rd_chk(13'h1004, 32'h0000_0000);
        rd_chk(13'h0008, 32'h0000_0000);
        wr(13'h0000, 32'he000_0000);
        rd_chk(13'h0000, 32'h0000_0000);
        wr(13'h0004, 32'hffff_ffff);
        rd_chk(13'h0004, 32'h0700_0000);
        wr(13'h0000, 32'h8000_0000);
        rd_chk(13'h0000, 32'h8000_0000);
        rd_chk(13'h0004, 32'h0000_0000);
        check({31'h0, reg_out.regulator_on}, 32'h1);
        wr(13'h0004, 32'h0400_0000);
        wr(13'h0000, 32'hffff_ffff);
        rd_chk(13'h0000, 32'hc000_0000);
        rd_chk(13'h0004, 32'h0000_0000);
        wr(13'h0004, 32'h0200_0000);
        wr(13'h0000, 32'hffff_ffff);
        rd_chk(13'h0000, 32'he000_0000);
        rd_chk(13'h0004, 32'h0000_0000);
        wr(13'h0000, 32'h0000_0000);
        rd_chk(13'h0000, 32'he000_0000);
        check({29'h0, reg_out[3:1]}, 32'h0000_0007);

        // Standby follows the chip mode only where its control bit is set.
        @(posedge clk_sys);
        stop_mode <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check({31'h0, reg_out.regulator_in_standby}, 32'h1);
        stop_mode <= 1'b0;
        lowpower_run <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check({31'h0, reg_out.regulator_in_standby}, 32'h1);
        lowpower_run <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check({31'h0, reg_out.regulator_in_standby}, 32'h0);

        // Wake from low-leakage stop keeps the unlock bits; a system reset clears them.
        wr(13'h0004, 32'h0100_0000);
        @(posedge clk_sys);
        very_low_leakage_stop_exit <= 1'b1;
        @(posedge clk_sys);
        very_low_leakage_stop_exit <= 1'b0;
        rd_chk(13'h0004, 32'h0100_0000);
        rd_chk(13'h0000, 32'h0000_0000);
        @(posedge clk_sys);
        stop_mode <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check({31'h0, reg_out.regulator_in_standby}, 32'h0);
        stop_mode <= 1'b0;
        do_reset();
        rd_chk(13'h0004, 32'h0000_0000);

        // ****************************************************************
        // Clock source selection table
        // ****************************************************************
        wr(13'h1004, 32'hffff_ffff);
        rd_chk(13'h1004, 32'h0f05_00f0);
        for (int k = 0; k < 8; k++) begin
            w = {4'h0, k[1:0], k[1:0], 5'h0, k[0], 2'b00, 8'h0, k[2:0], k[0], 4'h0};
            wr(13'h1004, w);
            for (int p = 0; p < 8; p++) begin
                pat = (p == 7) ? 7'h7f : 7'h01 << p;
                @(posedge clk_sys);
                clk_in <= pat;
                repeat (3) @(posedge clk_sys);
                #1;
                check({27'h0, clk_out}, {27'h0, exp_clk(w, pat)});
            end
        end

        // Loop choice one: halved phase clock, frequency clock held low.
        @(posedge clk_sys);
        clk_in <= '0;
        wr(13'h1004, 32'h0505_0000);
        nt = '{0, 0, 0};
        for (int i = 0; i < 24; i++) begin
            @(posedge clk_sys);
            clk_in.phase_locked_clock <= ~clk_in.phase_locked_clock;
            #1;
            if (i >= 8) begin
                nt[0] += int'(clk_out.serial_port_clock != prev[4]);
                nt[1] += int'(clk_out.timer_clock != prev[3]);
                nt[2] += int'(clk_out.usb_48m_clock != prev[2]);
            end
            prev = clk_out;
        end
        for (int j = 0; j < 3; j++) begin
            check({31'h0, nt[j] >= 7 && nt[j] <= 9}, 32'h1);
        end
        end_of_test();
    end

    // Cuts a hung run short.
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        end_of_test();
    end
endmodule // tb
